// ### rtl/lbpe_engine.sv
// Seven-output LED pattern engine: byte register bank, intensity frame
// timebase, two blink envelopes and open-drain output selection.
// Assumes the serial bus front end delivers decoded byte writes and reads.
`timescale 1ns/100ps
module lbpe_engine
    import lbpe_pkg::*;
#(
    parameter int unsigned SLOT_CYCLES_P = SLOT_CYCLES
)(
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   reg_wr_en_in,
    input  wire logic [3:0]             reg_wr_addr_in,
    input  wire logic [7:0]             reg_wr_data_in,
    input  wire logic                   reg_rd_en_in,
    input  wire logic [3:0]             reg_rd_addr_in,
    output logic      [7:0]             reg_rd_data_out,
    output logic                        reg_rd_valid_out,
    output logic      [NUM_OUTPUTS-1:0] led_output_pin_o_out,
    output logic      [NUM_OUTPUTS-1:0] led_output_pin_oe_out,
    output logic                        frame_tick_out
);

    localparam int unsigned SLOT_W = (SLOT_CYCLES_P > 1) ? $clog2(SLOT_CYCLES_P) : 1;

    logic [7:0]        output_state_sel_lo_reg;
    logic [7:0]        output_state_sel_mid_reg;
    logic [7:0]        output_state_sel_hi_reg;
    logic [7:0]        ramp_up_time_reg;
    logic [7:0]        hold_high_time_reg;
    logic [7:0]        ramp_down_time_reg;
    logic [7:0]        first_dark_time_reg;
    logic [7:0]        second_dark_time_reg;
    logic [7:0]        peak_intensity_reg;
    logic [7:0]        single_shot_master_level_reg;
    logic              restart_reg;
    logic [7:0]        rd_data_next;

    logic [SLOT_W-1:0] slot_cnt_reg;
    logic [3:0]        slot_idx_reg;
    logic              frame_tick_reg;
    logic              slot_wrap;

    logic [3:0]        master_level;
    logic [3:0]        channel_a_peak_value;
    logic [3:0]        channel_b_peak_value;
    logic [3:0]        chan_a_peak;
    logic [3:0]        chan_b_peak;
    logic [3:0]        chan_a_env;
    logic [3:0]        chan_b_env;
    logic              channel_a_modulator;
    logic              channel_b_modulator;
    logic              master_modulator;
    logic              peak_a_modulator;
    logic              peak_b_modulator;

    // Register bank writes; the address comes from the low nibble of the command byte
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            output_state_sel_lo_reg      <= RST_SEL;
            output_state_sel_mid_reg     <= RST_SEL;
            output_state_sel_hi_reg      <= RST_SEL;
            ramp_up_time_reg             <= RST_TIME;
            hold_high_time_reg           <= RST_TIME;
            ramp_down_time_reg           <= RST_TIME;
            first_dark_time_reg          <= RST_TIME;
            second_dark_time_reg         <= RST_TIME;
            peak_intensity_reg           <= RST_PEAK;
            single_shot_master_level_reg <= RST_MASTER;
        end else if (reg_wr_en_in) begin
            unique case (reg_wr_addr_in)
                ADDR_SEL_LO:    output_state_sel_lo_reg      <= reg_wr_data_in;
                ADDR_SEL_MID:   output_state_sel_mid_reg     <= reg_wr_data_in;
                ADDR_SEL_HI:    output_state_sel_hi_reg      <= reg_wr_data_in;
                ADDR_RAMP_UP:   ramp_up_time_reg             <= reg_wr_data_in;
                ADDR_HOLD_HIGH: hold_high_time_reg           <= reg_wr_data_in;
                ADDR_RAMP_DOWN: ramp_down_time_reg           <= reg_wr_data_in;
                ADDR_DARK_1:    first_dark_time_reg          <= reg_wr_data_in;
                ADDR_DARK_2:    second_dark_time_reg         <= reg_wr_data_in;
                ADDR_PEAK:      peak_intensity_reg           <= reg_wr_data_in;
                ADDR_MASTER:    single_shot_master_level_reg <= reg_wr_data_in;
                default:        ;
            endcase
        end
    end

    // Writing the initialization address stores nothing and restarts both envelopes
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= reg_wr_en_in && (reg_wr_addr_in == ADDR_INIT);
        end
    end

    // Read mux; the initialization and unused addresses read as zero
    always_comb begin
        unique case (reg_rd_addr_in)
            ADDR_SEL_LO:    rd_data_next = output_state_sel_lo_reg;
            ADDR_SEL_MID:   rd_data_next = output_state_sel_mid_reg;
            ADDR_SEL_HI:    rd_data_next = output_state_sel_hi_reg;
            ADDR_RAMP_UP:   rd_data_next = ramp_up_time_reg;
            ADDR_HOLD_HIGH: rd_data_next = hold_high_time_reg;
            ADDR_RAMP_DOWN: rd_data_next = ramp_down_time_reg;
            ADDR_DARK_1:    rd_data_next = first_dark_time_reg;
            ADDR_DARK_2:    rd_data_next = second_dark_time_reg;
            ADDR_PEAK:      rd_data_next = peak_intensity_reg;
            ADDR_MASTER:    rd_data_next = single_shot_master_level_reg;
            default:        rd_data_next = READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            reg_rd_data_out  <= READ_UNMAPPED;
            reg_rd_valid_out <= 1'b0;
        end else begin
            reg_rd_valid_out <= reg_rd_en_in;
            if (reg_rd_en_in) begin
                reg_rd_data_out <= rd_data_next;
            end
        end
    end

    // Timebase: fifteen duty slots make one intensity frame
    assign slot_wrap = (slot_cnt_reg == SLOT_W'(SLOT_CYCLES_P - 1));

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            slot_cnt_reg <= '0;
        end else if (slot_wrap) begin
            slot_cnt_reg <= '0;
        end else begin
            slot_cnt_reg <= slot_cnt_reg + SLOT_W'(1);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            slot_idx_reg   <= 4'h0;
            frame_tick_reg <= 1'b0;
        end else begin
            frame_tick_reg <= 1'b0;
            if (slot_wrap) begin
                if (slot_idx_reg == 4'(PWM_SLOTS - 1)) begin
                    slot_idx_reg   <= 4'h0;
                    frame_tick_reg <= 1'b1;
                end else begin
                    slot_idx_reg <= slot_idx_reg + 4'h1;
                end
            end
        end
    end

    assign frame_tick_out = frame_tick_reg;

    // Peak source per channel
    assign master_level         = single_shot_master_level_reg[MASTER_LVL_LSB +: 4];
    assign channel_a_peak_value = peak_intensity_reg[CHAN_A_LSB +: 4];
    assign channel_b_peak_value = peak_intensity_reg[CHAN_B_LSB +: 4];
    assign chan_a_peak = single_shot_master_level_reg[USE_MASTER_A] ? master_level
                                                                     : channel_a_peak_value;
    assign chan_b_peak = single_shot_master_level_reg[USE_MASTER_B] ? master_level
                                                                     : channel_b_peak_value;

    lbpe_envelope u_env_a (
        .core_clk_in   (core_clk_in),
        .rst_in        (rst_in),
        .frame_tick_in (frame_tick_reg),
        .restart_in    (restart_reg),
        .one_shot_in   (single_shot_master_level_reg[ONE_SHOT_A]),
        .rise_code_in  (ramp_up_time_reg[CHAN_A_LSB +: 4]),
        .hold_code_in  (hold_high_time_reg[CHAN_A_LSB +: 4]),
        .fall_code_in  (ramp_down_time_reg[CHAN_A_LSB +: 4]),
        .dark1_code_in (first_dark_time_reg[CHAN_A_LSB +: 4]),
        .dark2_code_in (second_dark_time_reg[CHAN_A_LSB +: 4]),
        .peak_in       (chan_a_peak),
        .level_out     (chan_a_env)
    );

    lbpe_envelope u_env_b (
        .core_clk_in   (core_clk_in),
        .rst_in        (rst_in),
        .frame_tick_in (frame_tick_reg),
        .restart_in    (restart_reg),
        .one_shot_in   (single_shot_master_level_reg[ONE_SHOT_B]),
        .rise_code_in  (ramp_up_time_reg[CHAN_B_LSB +: 4]),
        .hold_code_in  (hold_high_time_reg[CHAN_B_LSB +: 4]),
        .fall_code_in  (ramp_down_time_reg[CHAN_B_LSB +: 4]),
        .dark1_code_in (first_dark_time_reg[CHAN_B_LSB +: 4]),
        .dark2_code_in (second_dark_time_reg[CHAN_B_LSB +: 4]),
        .peak_in       (chan_b_peak),
        .level_out     (chan_b_env)
    );

    // A level of n lights n of the fifteen slots in each frame
    assign channel_a_modulator = chan_a_env > slot_idx_reg;
    assign channel_b_modulator = chan_b_env > slot_idx_reg;
    assign peak_a_modulator    = chan_a_peak > slot_idx_reg;
    assign peak_b_modulator    = chan_b_peak > slot_idx_reg;
    assign master_modulator    = master_level > slot_idx_reg;

    // Open-drain outputs: enable high pulls the LED pin low; bit 7 is not used
    genvar n;
    generate
        for (n = 0; n < NUM_OUTPUTS; n++) begin : g_out
            logic [2:0] mode;
            logic       drive_next;

            assign mode = {output_state_sel_hi_reg[n], output_state_sel_mid_reg[n],
                           output_state_sel_lo_reg[n]};

            always_comb begin
                unique case (mode)
                    3'h0, 3'h1: drive_next = 1'b0;
                    3'h2:       drive_next = peak_a_modulator;
                    3'h3:       drive_next = peak_b_modulator;
                    3'h4:       drive_next = 1'b1;
                    3'h5:       drive_next = master_modulator;
                    3'h6:       drive_next = channel_a_modulator;
                    3'h7:       drive_next = channel_b_modulator;
                endcase
            end

            always_ff @(posedge core_clk_in) begin
                if (rst_in) begin
                    led_output_pin_oe_out[n] <= 1'b0;
                    led_output_pin_o_out[n]  <= 1'b0;
                end else begin
                    led_output_pin_oe_out[n] <= drive_next;
                    led_output_pin_o_out[n]  <= 1'b0;
                end
            end
        end
    endgenerate

endmodule // lbpe_engine

// ### rtl/lbpe_envelope.sv
// Double-pulse blink envelope for one pattern channel.
// Assumes a one-cycle frame tick every intensity update period.
`timescale 1ns/100ps
module lbpe_envelope
    import lbpe_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    input  wire logic       frame_tick_in,
    input  wire logic       restart_in,
    input  wire logic       one_shot_in,
    input  wire logic [3:0] rise_code_in,
    input  wire logic [3:0] hold_code_in,
    input  wire logic [3:0] fall_code_in,
    input  wire logic [3:0] dark1_code_in,
    input  wire logic [3:0] dark2_code_in,
    input  wire logic [3:0] peak_in,
    output logic      [3:0] level_out
);

    lbpe_env_state_t  state_reg;
    lbpe_env_state_t  state_next;
    logic [SEG_W-1:0] seg_cnt_reg;
    logic [SEG_W:0]   acc_reg;
    logic [3:0]       ramp_reg;
    logic             halted_reg;
    logic [SEG_W-1:0] cur_len;
    logic [SEG_W:0]   acc_sum;
    logic             seg_done;

    function automatic lbpe_env_state_t succ(input lbpe_env_state_t s);
        unique case (s)
            ENV_RISE_1: succ = ENV_HOLD_1;
            ENV_HOLD_1: succ = ENV_FALL_1;
            ENV_FALL_1: succ = ENV_DARK_1;
            ENV_DARK_1: succ = ENV_RISE_2;
            ENV_RISE_2: succ = ENV_HOLD_2;
            ENV_HOLD_2: succ = ENV_FALL_2;
            ENV_FALL_2: succ = ENV_DARK_2;
            ENV_DARK_2: succ = ENV_RISE_1;
        endcase
    endfunction

    function automatic logic [SEG_W-1:0] seg_len(input lbpe_env_state_t s, input logic [3:0] r,
                                                 input logic [3:0] h, input logic [3:0] f,
                                                 input logic [3:0] d1, input logic [3:0] d2);
        unique case (s)
            ENV_RISE_1, ENV_RISE_2: seg_len = lbpe_code_frames(r);
            ENV_HOLD_1, ENV_HOLD_2: seg_len = lbpe_code_frames(h);
            ENV_FALL_1, ENV_FALL_2: seg_len = lbpe_code_frames(f);
            ENV_DARK_1:             seg_len = lbpe_code_frames(d1);
            ENV_DARK_2:             seg_len = lbpe_code_frames(d2);
        endcase
    endfunction

    assign cur_len  = seg_len(state_reg, rise_code_in, hold_code_in, fall_code_in, dark1_code_in, dark2_code_in);
    assign seg_done = (seg_cnt_reg + SEG_W'(1)) >= cur_len;
    assign acc_sum  = acc_reg + {{(SEG_W-3){1'b0}}, peak_in};

    // Next segment, passing over zero-length ones
    always_comb begin
        state_next = succ(state_reg);
        for (int i = 0; i < 7; i++) begin
            if (seg_len(state_next, rise_code_in, hold_code_in, fall_code_in,
                        dark1_code_in, dark2_code_in) == '0) begin
                state_next = succ(state_next);
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in || restart_in) begin
            state_reg   <= ENV_RISE_1;
            seg_cnt_reg <= '0;
            halted_reg  <= 1'b0;
        end else if (frame_tick_in && !halted_reg) begin
            if (seg_done) begin
                seg_cnt_reg <= '0;
                if (one_shot_in && state_reg == ENV_DARK_2) begin
                    halted_reg <= 1'b1;
                end else begin
                    state_reg <= state_next;
                end
            end else begin
                seg_cnt_reg <= seg_cnt_reg + SEG_W'(1);
            end
        end
    end

    // Ramp level advances by peak/length per frame, at most two steps
    always_ff @(posedge core_clk_in) begin
        if (rst_in || restart_in) begin
            acc_reg  <= '0;
            ramp_reg <= 4'h0;
        end else if (frame_tick_in && !halted_reg) begin
            if (seg_done) begin
                acc_reg  <= '0;
                ramp_reg <= (state_next == ENV_FALL_1 || state_next == ENV_FALL_2) ? peak_in : 4'h0;
            end else if (acc_sum >= {cur_len, 1'b0}) begin
                acc_reg  <= acc_sum - {cur_len, 1'b0};
                ramp_reg <= (state_reg == ENV_RISE_1 || state_reg == ENV_RISE_2) ?
                            ((ramp_reg + 4'h2 > peak_in || ramp_reg > 4'hD) ? peak_in : ramp_reg + 4'h2) :
                            ((ramp_reg < 4'h2) ? 4'h0 : ramp_reg - 4'h2);
            end else if (acc_sum >= {1'b0, cur_len}) begin
                acc_reg  <= acc_sum - {1'b0, cur_len};
                ramp_reg <= (state_reg == ENV_RISE_1 || state_reg == ENV_RISE_2) ?
                            ((ramp_reg >= peak_in) ? peak_in : ramp_reg + 4'h1) :
                            ((ramp_reg == 4'h0) ? 4'h0 : ramp_reg - 4'h1);
            end else begin
                acc_reg <= acc_sum;
            end
        end
    end

    always_comb begin
        if (halted_reg) begin
            level_out = 4'h0;
        end else begin
            unique case (state_reg)
                ENV_HOLD_1, ENV_HOLD_2: level_out = peak_in;
                ENV_DARK_1, ENV_DARK_2: level_out = 4'h0;
                default:                level_out = (ramp_reg > peak_in) ? peak_in : ramp_reg;
            endcase
        end
    end

endmodule // lbpe_envelope

// ### rtl/lbpe_pkg.sv
// Shared constants for the LED blink pattern engine: register map,
// power-up values, field positions, timing table and envelope states.
// Assumes a 200 MHz core clock.
package lbpe_pkg;

    // Register map, 4-bit addresses
    localparam logic [3:0] ADDR_SEL_LO     = 4'h0;
    localparam logic [3:0] ADDR_SEL_MID    = 4'h1;
    localparam logic [3:0] ADDR_SEL_HI     = 4'h2;
    localparam logic [3:0] ADDR_RAMP_UP    = 4'h3;
    localparam logic [3:0] ADDR_HOLD_HIGH  = 4'h4;
    localparam logic [3:0] ADDR_RAMP_DOWN  = 4'h5;
    localparam logic [3:0] ADDR_DARK_1     = 4'h6;
    localparam logic [3:0] ADDR_DARK_2     = 4'h7;
    localparam logic [3:0] ADDR_PEAK       = 4'h8;
    localparam logic [3:0] ADDR_MASTER     = 4'h9;
    localparam logic [3:0] ADDR_INIT       = 4'hA;

    // Power-up values
    localparam logic [7:0] RST_SEL         = 8'h00;
    localparam logic [7:0] RST_TIME        = 8'h44;
    localparam logic [7:0] RST_PEAK        = 8'hFF;
    localparam logic [7:0] RST_MASTER      = 8'h0F;
    localparam logic [7:0] READ_UNMAPPED   = 8'h00;

    // Field positions
    localparam int unsigned CHAN_A_LSB     = 0;
    localparam int unsigned CHAN_B_LSB     = 4;
    localparam int unsigned MASTER_LVL_LSB = 0;
    localparam int unsigned USE_MASTER_A   = 4;
    localparam int unsigned USE_MASTER_B   = 5;
    localparam int unsigned ONE_SHOT_A     = 6;
    localparam int unsigned ONE_SHOT_B     = 7;
    localparam int unsigned NUM_OUTPUTS    = 7;

    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned FRAME_MS       = 8;
    localparam int unsigned FRAME_NS       = FRAME_MS * 1000000;
    localparam int unsigned FRAME_CYCLES   = FRAME_NS / CLK_PERIOD_NS;
    localparam int unsigned PWM_SLOTS      = 15;
    localparam int unsigned SLOT_CYCLES    = FRAME_CYCLES / PWM_SLOTS;
    localparam int unsigned SEG_W          = 11;

    localparam int unsigned TIME_MS_TABLE [0:15] = '{0, 64, 128, 192, 256, 384, 512, 768,
                                                    1024, 1536, 2048, 3072, 4096, 5760, 8128, 16320};

    // Segment length in intensity frames for a 4-bit time code
    function automatic logic [SEG_W-1:0] lbpe_code_frames(input logic [3:0] code);
        lbpe_code_frames = SEG_W'(TIME_MS_TABLE[code] / FRAME_MS);
    endfunction

    typedef enum logic [7:0] {
        ENV_RISE_1 = 8'h01,
        ENV_HOLD_1 = 8'h02,
        ENV_FALL_1 = 8'h04,
        ENV_DARK_1 = 8'h08,
        ENV_RISE_2 = 8'h10,
        ENV_HOLD_2 = 8'h20,
        ENV_FALL_2 = 8'h40,
        ENV_DARK_2 = 8'h80
    } lbpe_env_state_t;

endpackage

// ### tb/lbpe_engine_checker.sv
// Port checker for the pattern engine: read answers, frame tick, pin modes.
// Assumes it is bound to lbpe_engine with the same slot parameter.
`timescale 1ns/100ps
module lbpe_engine_checker
    import lbpe_pkg::*;
#(
    parameter int unsigned SLOT_CYCLES_P = SLOT_CYCLES
)(
    input wire logic                   core_clk_in,
    input wire logic                   rst_in,
    input wire logic                   reg_wr_en_in,
    input wire logic [3:0]             reg_wr_addr_in,
    input wire logic [7:0]             reg_wr_data_in,
    input wire logic                   reg_rd_en_in,
    input wire logic [3:0]             reg_rd_addr_in,
    input wire logic [7:0]             reg_rd_data_out,
    input wire logic                   reg_rd_valid_out,
    input wire logic [NUM_OUTPUTS-1:0] led_output_pin_o_out,
    input wire logic [NUM_OUTPUTS-1:0] led_output_pin_oe_out,
    input wire logic                   frame_tick_out
);
    localparam int unsigned FRAME_C = SLOT_CYCLES_P * PWM_SLOTS;
    logic [7:0]             sel_reg [0:2];
    logic [31:0]            gap_reg;
    logic                   seen_reg;
    logic [NUM_OUTPUTS-1:0] off_mask;
    logic [NUM_OUTPUTS-1:0] gpio_mask;

    // Shadow of the selectors, taken from the write port
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sel_reg <= '{8'h00, 8'h00, 8'h00};
        end else if (reg_wr_en_in && reg_wr_addr_in < 4'h3) begin
            sel_reg[reg_wr_addr_in[1:0]] <= reg_wr_data_in;
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (rst_in || frame_tick_out) begin
            gap_reg <= 32'h0;
        end else begin
            gap_reg <= gap_reg + 32'h1;
        end
    end
    always_ff @(posedge core_clk_in) begin
        seen_reg <= rst_in ? 1'b0 : (seen_reg | frame_tick_out);
    end
    assign off_mask  = ~sel_reg[2][6:0] & ~sel_reg[1][6:0];
    assign gpio_mask = sel_reg[2][6:0] & ~sel_reg[1][6:0] & ~sel_reg[0][6:0];

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_rd_req;
        reg_rd_en_in ##1 reg_rd_valid_out;
    endsequence

    a_rd_answer:    assert property (reg_rd_en_in |-> s_rd_req) else $error("read not answered");
    a_rd_single:    assert property (reg_rd_valid_out |-> $past(reg_rd_en_in)) else $error("stray valid");
    a_unmapped_rd:  assert property (reg_rd_en_in && reg_rd_addr_in > 4'h9 |=>
        reg_rd_data_out == READ_UNMAPPED) else $error("unmapped read not zero");
    a_pin_drain:    assert property (led_output_pin_o_out == '0) else $error("pin driven high");
    a_frame_period: assert property (frame_tick_out && seen_reg |-> gap_reg == FRAME_C - 1)
        else $error("frame period wrong");
    a_tick_single:  assert property (frame_tick_out |=> !frame_tick_out) else $error("tick too long");
    a_led_off:      assert property ((led_output_pin_oe_out & $past(off_mask)) == '0)
        else $error("released pin driven");
    a_led_gpio:     assert property ((led_output_pin_oe_out & $past(gpio_mask)) == $past(gpio_mask))
        else $error("plain output not low");
endmodule // lbpe_engine_checker

// ### tb/lbpe_led_load.sv
// Open-drain LED pins with pull-ups: a pin reads low only while driven.
// Assumes the enable is high while the engine pulls its pin.
`timescale 1ns/100ps
module lbpe_led_load
    import lbpe_pkg::*;
(
    input  wire logic [NUM_OUTPUTS-1:0] drive_in,
    input  wire logic [NUM_OUTPUTS-1:0] data_in,
    output logic      [NUM_OUTPUTS-1:0] level_out
);
    always_comb begin
        for (int n = 0; n < NUM_OUTPUTS; n++) begin
            level_out[n] = drive_in[n] ? data_in[n] : 1'b1;
        end
    end
endmodule // lbpe_led_load

// ### tb/led_blink_pattern_engine_test.sv
// Self-checking bench: register map, pin modes and frame duty of the engine.
// Assumes a 4-cycle slot so one frame lasts 60 cycles.
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module led_blink_pattern_engine_test;
    import lbpe_pkg::*;
    localparam int unsigned SLOTS_P = 4;
    localparam int unsigned FRM     = SLOTS_P * PWM_SLOTS;
    logic       core_clk_in = 1'b0;
    logic       rst_in      = 1'b1;
    logic       wr_en       = 1'b0;
    logic [3:0] wr_addr     = 4'h0;
    logic [7:0] wr_data     = 8'h00;
    logic       rd_en       = 1'b0;
    logic [3:0] rd_addr     = 4'h0;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic [6:0] pin_o;
    logic [6:0] pin_oe;
    logic [6:0] pin_lvl;
    logic       tick;
    logic [7:0] mdl [0:15];
    logic [7:0] d;
    int         mismatches = 0;
    int         checked    = 0;
    int         cycles     = 0;

    always #2.5 core_clk_in = ~core_clk_in;
    lbpe_engine #(.SLOT_CYCLES_P(SLOTS_P)) dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .reg_wr_en_in(wr_en), .reg_wr_addr_in(wr_addr), .reg_wr_data_in(wr_data), .reg_rd_en_in(rd_en),
        .reg_rd_addr_in(rd_addr), .reg_rd_data_out(rd_data), .reg_rd_valid_out(rd_valid),
        .led_output_pin_o_out(pin_o), .led_output_pin_oe_out(pin_oe), .frame_tick_out(tick));
    lbpe_led_load load (.drive_in(pin_oe), .data_in(pin_o), .level_out(pin_lvl));

    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk_in); #1;
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = v;
        @(posedge core_clk_in); #1;
        wr_en = 1'b0;
        if (a < 4'hA) mdl[a] = v;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk_in); #1;
        rd_en = 1'b1;
        rd_addr = a;
        @(posedge core_clk_in); #1;
        rd_en = 1'b0;
        `CHK(rd_valid, 1'b1)
        `CHK(rd_data, mdl[a])
    endtask
    // Low cycles of pin 0 over a number of whole frames
    task automatic duty(input int exp, input int frames = 1);
        int cnt;
        cnt = 0;
        repeat (2) @(posedge tick);
        repeat (frames * FRM) begin
            @(posedge core_clk_in); #1;
            cnt += (pin_lvl[0] === 1'b0);
        end
        `CHK(cnt, exp)
    endtask

    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(54));
        for (int i = 0; i < 16; i++) mdl[i] = (i < 3) ? RST_SEL : (i < 8) ? RST_TIME : READ_UNMAPPED;
        mdl[8] = RST_PEAK;
        mdl[9] = RST_MASTER;
        repeat (6) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        for (int a = 0; a < 16; a++) rd(a[3:0]);
        $display("test reset values done");
        for (int a = 0; a < 12; a++) wr(a[3:0], 8'($urandom));
        for (int a = 0; a < 12; a++) rd(a[3:0]);
        $display("test readback done");
        wr(ADDR_SEL_LO, 8'h00);
        wr(ADDR_SEL_MID, 8'h00);
        d = 8'($urandom);
        wr(ADDR_SEL_HI, d);
        @(posedge core_clk_in); #1;
        `CHK(pin_lvl, ~d[6:0])
        wr(ADDR_SEL_HI, 8'h00);
        wr(ADDR_SEL_LO, 8'h7F);
        @(posedge core_clk_in); #1;
        `CHK(pin_lvl, 7'h7F)
        $display("test plain outputs done");
        wr(ADDR_SEL_HI, 8'h7F);
        for (int j = 0; j < 3; j++) begin
            d = (j == 0) ? 8'h00 : (j == 1) ? 8'h0F : 8'($urandom % 16);
            wr(ADDR_MASTER, d);
            duty(d * SLOTS_P);
        end
        $display("test master level done");
        d = 8'($urandom);
        wr(ADDR_PEAK, d);
        for (int j = 0; j < 2; j++) begin
            wr(ADDR_SEL_HI, 8'h00);
            wr(ADDR_SEL_MID, 8'h7F);
            wr(ADDR_SEL_LO, j ? 8'h7F : 8'h00);
            wr(ADDR_MASTER, 8'h00);
            duty((j ? d[7:4] : d[3:0]) * SLOTS_P);
            wr(ADDR_MASTER, (j ? 8'h20 : 8'h10) | 8'h09);
            duty(9 * SLOTS_P);
        end
        $display("test channel peaks done");
        // Rise and fall skipped: pulses of 8 frames, darks of 8 and 16 frames
        d = 8'($urandom) | 8'h11;
        wr(ADDR_RAMP_UP, 8'h00);
        wr(ADDR_HOLD_HIGH, 8'h11);
        wr(ADDR_RAMP_DOWN, 8'h00);
        wr(ADDR_DARK_1, 8'h11);
        wr(ADDR_DARK_2, 8'h22);
        wr(ADDR_PEAK, d);
        wr(ADDR_MASTER, 8'h00);
        wr(ADDR_SEL_HI, 8'h7F);
        wr(ADDR_SEL_LO, 8'h00);
        wr(ADDR_INIT, 8'h00);
        duty(16 * d[3:0] * SLOTS_P, 40);
        wr(ADDR_SEL_LO, 8'h7F);
        duty(16 * d[7:4] * SLOTS_P, 40);
        wr(ADDR_MASTER, 8'h40);
        wr(ADDR_SEL_LO, 8'h00);
        wr(ADDR_INIT, 8'h00);
        repeat (45) @(posedge tick);
        duty(0, 8);
        $display("test blink envelopes done");
        complete_run();
    end
endmodule // led_blink_pattern_engine_test

bind lbpe_engine lbpe_engine_checker #(.SLOT_CYCLES_P(SLOT_CYCLES_P)) chk (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .reg_wr_en_in(reg_wr_en_in), .reg_wr_addr_in(reg_wr_addr_in),
    .reg_wr_data_in(reg_wr_data_in), .reg_rd_en_in(reg_rd_en_in), .reg_rd_addr_in(reg_rd_addr_in),
    .reg_rd_data_out(reg_rd_data_out), .reg_rd_valid_out(reg_rd_valid_out),
    .led_output_pin_o_out(led_output_pin_o_out), .led_output_pin_oe_out(led_output_pin_oe_out),
    .frame_tick_out(frame_tick_out));
